/* dv/core_memory_model.sv */
// Memory unit side model: sync source, enable gate and command pins
`timescale 1ns/1ps
`default_nettype none

module core_memory_model
  import tape_unit_pkg::*;
#(
  parameter int HALF_CYC = 4
)(
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic sync_on, // Run the sync pair
  input wire logic enable_on, // Operation wanted
  input wire tape_cmd_t cmd_in, // Command levels
  input wire logic strobe_req, // Record one word
  input wire logic [TRACKS-1:0] word_in, // Word to record
  input wire logic supply_fail_flag, // Supply state of the unit
  output logic sync_pair, // Sync
  output logic sync_pair_return, // Sync complement
  output logic operate_enable, // Enable level
  output var tape_cmd_t cmd_pins, // Command pins
  output logic [TRACKS-1:0] write_track // Track lines
);
  logic [3:0] div_q;
  logic [3:0] stb_q;
  wire logic div_end = (div_q == 4'(HALF_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 4'h0;
      sync_pair <= 1'h0;
      stb_q <= 4'h0;
    end
    else
    begin
      div_q <= div_end ? 4'h0 : div_q + 4'h1;
      if (sync_on && div_end)
        sync_pair <= ~sync_pair;
      stb_q <= strobe_req ? 4'hc : (stb_q == 4'h0 ? 4'h0 : stb_q - 4'h1);
    end
  end

  // Sync halts at its last level when removed, so the unit must spot the loss
  assign sync_pair_return = ~sync_pair;
  // Enable only once the supply has settled
  assign operate_enable = enable_on & ~supply_fail_flag;
  // Word stands around the strobe; the inverse shows otherwise
  assign write_track = (stb_q != 4'h0) ? word_in : ~word_in;
  always_comb
  begin
    cmd_pins = cmd_in;
    cmd_pins.word_write_strobe = (stb_q > 4'h3) && (stb_q < 4'ha);
  end
endmodule : core_memory_model
`default_nettype wire

/* dv/tape_unit_control_interface_test.sv */
// Self-checking bench for the tape unit control interface
`timescale 1ns/1ps
`default_nettype none

module tape_unit_control_interface_test
  import tape_unit_pkg::*;
;
  localparam int SC = 100, RC = 50, RMC = 200, FC = 40, SPC = 60, STC = 20, RDC = 5, SLC = 16;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic sync_on = 1'h0, enable_on = 1'h0, strobe_req = 1'h0;
  logic sync_pair, sync_pair_return, operate_enable, not_ready_n, supply_fail_flag;
  logic tape_start_mark, tape_middle_mark, tape_end_mark, speed_ok_forward, speed_ok_reverse;
  logic [TRACKS-1:0] word_in = 18'h0, write_track, read_track;
  tape_cmd_t cmd_in = 7'h0, cmd_pins;
  int err_total = 0, n_compared = 0, n;

  tape_unit_ctrl #(.TAPE_WORDS(8), .STANDBY_CYC(SC), .READY_CYC(RC), .READY_MAX_CYC(RMC),
    .FAIL_CYC(FC), .SPEED_CYC(SPC), .READ_CYC(RDC), .SYNC_LOSS_CYC(SLC), .STEP_CYC(STC)) DUT (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sync_pair(sync_pair),
    .sync_pair_return(sync_pair_return), .operate_enable(operate_enable), .cmd_pins(cmd_pins),
    .write_track(write_track), .read_track(read_track), .tape_start_mark(tape_start_mark),
    .tape_middle_mark(tape_middle_mark), .tape_end_mark(tape_end_mark),
    .speed_ok_forward(speed_ok_forward), .speed_ok_reverse(speed_ok_reverse),
    .not_ready_n(not_ready_n), .supply_fail_flag(supply_fail_flag));

  core_memory_model #(.HALF_CYC(4)) far_end (.clk(clk), .rst_n(rst_n), .sync_on(sync_on),
    .enable_on(enable_on), .cmd_in(cmd_in), .strobe_req(strobe_req), .word_in(word_in),
    .supply_fail_flag(supply_fail_flag), .sync_pair(sync_pair),
    .sync_pair_return(sync_pair_return), .operate_enable(operate_enable),
    .cmd_pins(cmd_pins), .write_track(write_track));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low; only the watchdog ends a lost answer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask : bus

  task automatic await(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : await

  task automatic put(input logic [TRACKS-1:0] w, input logic lock_n, input logic wen);
    word_in <= w;
    cmd_in.write_lockout_n <= lock_n;
    cmd_in.write_enable_level <= wen;
    strobe_req <= 1'h1;
    @(posedge clk);
    strobe_req <= 1'h0;
    repeat (20) @(posedge clk);
  endtask : put

  task automatic t_reset;
    check({supply_fail_flag, not_ready_n, avs_waitrequest, tape_start_mark}, 32'he);
    bus(1'h0, REG_STATUS, 32'h0);
    check(rd, 32'h30);
    bus(1'h0, 4'hc, 32'h0);
    check(rd, 32'h0);
    bus(1'h0, REG_CTRL, 32'h0);
    check(rd, 32'h0);
  endtask : t_reset

  task automatic t_power;
    sync_on <= 1'h1;
    await(supply_fail_flag, 1'h0, SC + 40);
    check(32'(n >= SC * 9 / 10 && n < SC + 40), 32'h1);
    cmd_in.write_lockout_n <= 1'h1;
    enable_on <= 1'h1;
    await(not_ready_n, 1'h0, RMC);
    check(32'(n < RMC), 32'h1);
    check({tape_start_mark, tape_middle_mark, tape_end_mark}, 32'h4);
    bus(1'h0, REG_STATUS, 32'h0);
    check(rd[2:0], 32'h4);
  endtask : t_power

  task automatic t_record;
    put(18'h2a5a5, 1'h1, 1'h1);
    put(18'h15a5a, 1'h0, 1'h1);
    put(18'h3ffff, 1'h1, 1'h0);
    cmd_in.read_cmd <= 1'h1;
    cmd_in.advance_cmd <= 1'h1;
    for (n = 0; read_track === 18'h0 && n < 3 * STC; n++)
      @(posedge clk);
    check(32'(read_track), 32'h2a5a5);
    await(tape_start_mark, 1'h0, STC);
    await(speed_ok_forward, 1'h1, 2 * SPC);
    check(32'(n >= SPC * 9 / 10 - 3 && n <= SPC * 11 / 10 + 3), 32'h1);
    check({speed_ok_forward, speed_ok_reverse}, 32'h2);
    await(tape_end_mark, 1'h1, 10 * STC);
    check(32'(n < 10 * STC), 32'h1);
    cmd_in.advance_cmd <= 1'h0;
    cmd_in.read_cmd <= 1'h0;
    cmd_in.rewind_cmd <= 1'h1;
    await(tape_start_mark, 1'h1, 10 * STC);
    check(32'(n < 10 * STC), 32'h1);
    await(speed_ok_reverse, 1'h1, 2 * SPC);
    check({speed_ok_forward, speed_ok_reverse}, 32'h1);
    cmd_in.rewind_cmd <= 1'h0;
    cmd_in.erase_override <= 1'h1;
    repeat (10) @(posedge clk);
    cmd_in.erase_override <= 1'h0;
    cmd_in.read_cmd <= 1'h1;
    cmd_in.advance_cmd <= 1'h1;
    await(tape_start_mark, 1'h0, 3 * STC);
    rd = 32'h0;
    repeat (RDC)
    begin
      @(posedge clk);
      rd = rd | 32'(read_track);
    end
    check(rd, 32'h0);
    cmd_in.advance_cmd <= 1'h0;
    cmd_in.read_cmd <= 1'h0;
  endtask : t_record

  task automatic t_standby;
    logic [31:0] p;
    enable_on <= 1'h0;
    await(not_ready_n, 1'h1, OFFLINE_MAX_CYC);
    check(32'(n < OFFLINE_MAX_CYC), 32'h1);
    check(supply_fail_flag, 1'h0);
    bus(1'h0, REG_POS, 32'h0);
    p = rd;
    cmd_in.rewind_cmd <= 1'h1;
    repeat (3 * STC) @(posedge clk);
    bus(1'h0, REG_POS, 32'h0);
    check(rd, p);
    cmd_in.rewind_cmd <= 1'h0;
  endtask : t_standby

  task automatic t_fault;
    bus(1'h1, REG_CTRL, 32'h1);
    await(supply_fail_flag, 1'h1, FC + 30);
    check(32'(n >= FC - 3 && n < FC + 30), 32'h1);
    bus(1'h0, REG_CTRL, 32'h0);
    check(rd[0], 32'h1);
    bus(1'h1, REG_STATUS, 32'h0);
    bus(1'h0, REG_STATUS, 32'h0);
    check(rd[5:4], 32'h3);
    bus(1'h1, REG_CTRL, 32'h0);
    await(supply_fail_flag, 1'h0, LEAD_CYC + SC + 60);
    check(32'(n < LEAD_CYC + SC + 60), 32'h1);
  endtask : t_fault

  task automatic t_loss;
    sync_on <= 1'h0;
    repeat (FC) @(posedge clk);
    check(supply_fail_flag, 1'h0);
    await(supply_fail_flag, 1'h1, SLC + 30);
    check(32'(n < SLC + 30), 32'h1);
    bus(1'h0, REG_STATUS, 32'h0);
    check(rd[2:0], 32'h6);
    repeat (LEAD_CYC) @(posedge clk);
    bus(1'h0, REG_STATUS, 32'h0);
    check(rd[2:0], 32'h0);
  endtask : t_loss

  // Sized for about 3350 cycles of scenarios
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_power();
    t_record();
    t_standby();
    t_fault();
    t_loss();
    finish_test();
  end
endmodule : tape_unit_control_interface_test
`default_nettype wire

/* rtl/tape_unit_ctrl.sv */
// Tape unit control interface: power states, motion, record and replay
//
// Notes on behaviour
// - Operate enable held high moves the unit from standby to on.
// - Rewind held high moves the tape toward its start.
// - Advance held high moves the tape toward its end.
// - Read held high presents recorded words on the read tracks.
// - Each write strobe pulse records exactly one word.
// - Recording happens only while write enable level is high; erase override here writes the tape regardless of that level.
// - Grounded write lockout blocks every recording.
// - Erase override forces the heads to write continuously.
// - Write track n is recorded on tape track n.
// - Read track n carries what tape track n holds.
// - Start, middle and end marks stand while the tape sits there.
// - Speed ok rises one second after the later command or mark clear.
// - Not ready falls within 500 ms of sync and enable.
// - Supply fail flag is low in normal supply operation.
// - Flag rises at least 300 us after loss, 10 us before bad outputs.
// - Sync arrival energises the supply, flag clears after about 100 ms.
// - Enable removal returns to standby, not ready high, flag low.
// - Sync removal returns to off with the flag high.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tape_unit_ctrl
  import tape_unit_pkg::*;
#(
  parameter int TAPE_WORDS = 64,
  parameter int STANDBY_CYC = STANDBY_CYC_D,
  parameter int READY_CYC = READY_CYC_D,
  parameter int READY_MAX_CYC = READY_MAX_CYC_D,
  parameter int FAIL_CYC = FAIL_CYC_D,
  parameter int SPEED_CYC = SPEED_CYC_D,
  parameter int READ_CYC = READ_CYC_D,
  parameter int SYNC_LOSS_CYC = SYNC_LOSS_CYC_D,
  parameter int STEP_CYC = STEP_CYC_D
)(
  input wire logic clk, // 125 MHz
  input wire logic rst_n, // Async reset
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic sync_pair, // Supply sync
  input wire logic sync_pair_return, // Complement of sync
  input wire logic operate_enable, // Go on
  input wire tape_cmd_t cmd_pins, // Motion and write commands
  input wire logic [TRACKS-1:0] write_track, // Word to record
  output logic [TRACKS-1:0] read_track, // Word replayed
  output logic tape_start_mark, // At start
  output logic tape_middle_mark, // At middle
  output logic tape_end_mark, // At end
  output logic speed_ok_forward, // Advancing at speed
  output logic speed_ok_reverse, // Rewinding at speed
  output logic not_ready_n, // Low when on
  output logic supply_fail_flag // Supply not good
);

  localparam int POS_W = $clog2(TAPE_WORDS);
  localparam int CMD_W = $bits(tape_cmd_t);
  localparam int PIN_W = 3 + CMD_W + TRACKS;

  generate
    if (TAPE_WORDS < 4 || STEP_CYC < 2 || READ_CYC >= STEP_CYC ||
        READY_CYC > READY_MAX_CYC || SYNC_LOSS_CYC < 2)
    begin : g_bad_params
      $error("tape_unit_ctrl: parameter set not supported");
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pin synchronisers; the first stage feeds only the second
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] pin_q;
  logic sync_old_q;
  logic strobe_old_q;
  tape_cmd_t cmd;
  logic sync_now;
  logic sync_ret;
  logic op_en;
  logic [TRACKS-1:0] wr_data;
  logic strobe_rise;

  assign pins_raw = {sync_pair, sync_pair_return, operate_enable, cmd_pins, write_track};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      pin_q <= '0;
      sync_old_q <= 1'b0;
      strobe_old_q <= 1'b0;
    end
    else
    begin
      meta_q <= pins_raw;
      pin_q <= meta_q;
      sync_old_q <= pin_q[PIN_W-1];
      strobe_old_q <= cmd.word_write_strobe;
    end
  end

  assign sync_now = pin_q[PIN_W-1];
  assign sync_ret = pin_q[PIN_W-2];
  assign op_en = pin_q[PIN_W-3];
  assign cmd = tape_cmd_t'(pin_q[TRACKS +: CMD_W]);
  assign wr_data = pin_q[TRACKS-1:0];
  assign strobe_rise = cmd.word_write_strobe && !strobe_old_q;

  // Sync watchdog: a steady pair, even if complementary, counts as lost
  logic [31:0] live_q;
  logic sync_ok;
  logic sync_toggle;

  assign sync_toggle = (sync_now != sync_old_q) && (sync_now != sync_ret);
  assign sync_ok = (live_q != 32'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      live_q <= 32'h0;
    else if (sync_toggle)
      live_q <= 32'(SYNC_LOSS_CYC);
    else if (sync_ok)
      live_q <= live_q - 32'h1;
  end

  // Register bus
  logic fault_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic bus_req;
  logic bus_done;
  logic [31:0] status_w;
  logic [31:0] rdata_w;

  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !wait_q;

  // Software fault injection stands for an internal supply failure
  logic power_bad;
  assign power_bad = !sync_ok || fault_q;

  // Power sequencer
  pwr_state_t st_q;
  pwr_state_t st_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;

  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q + 32'h1;
    unique case (st_q)
      ST_OFF:
      begin
        tmr_d = 32'h0;
        if (sync_ok && !fault_q)
          st_d = ST_POWERUP;
      end
      ST_POWERUP:
      begin
        if (power_bad)
        begin
          st_d = ST_OFF;
          tmr_d = 32'h0;
        end
        else if (tmr_q == 32'(STANDBY_CYC - 1))
        begin
          st_d = ST_STANDBY;
          tmr_d = 32'h0;
        end
      end
      ST_STANDBY:
      begin
        tmr_d = 32'h0;
        if (power_bad)
          st_d = ST_FAIL_WAIT;
        else if (op_en)
          st_d = ST_WARMUP;
      end
      ST_WARMUP:
      begin
        if (power_bad)
        begin
          st_d = ST_FAIL_WAIT;
          tmr_d = 32'h0;
        end
        else if (!op_en)
        begin
          st_d = ST_STANDBY;
          tmr_d = 32'h0;
        end
        else if (tmr_q == 32'(READY_CYC - 1))
        begin
          st_d = ST_ON;
          tmr_d = 32'h0;
        end
      end
      ST_ON:
      begin
        tmr_d = 32'h0;
        if (power_bad)
          st_d = ST_FAIL_WAIT;
        else if (!op_en)
          st_d = ST_STANDBY;
      end
      ST_FAIL_WAIT:
      begin
        // Flag held back at least the minimum delay after the loss
        if (tmr_q == 32'(FAIL_CYC - 1))
        begin
          st_d = ST_FAIL_HOLD;
          tmr_d = 32'h0;
        end
      end
      ST_FAIL_HOLD:
      begin
        // Outputs stay valid for the lead time after the flag rises
        if (tmr_q == 32'(LEAD_CYC - 1))
        begin
          st_d = ST_OFF;
          tmr_d = 32'h0;
        end
      end
    endcase
  end

  logic flag_d;
  assign flag_d = (st_d == ST_OFF) || (st_d == ST_POWERUP) || (st_d == ST_FAIL_HOLD);

  logic nrdy_q;
  logic flag_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_OFF;
      tmr_q <= 32'h0;
      nrdy_q <= 1'b1;
      flag_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      nrdy_q <= (st_d != ST_ON);
      flag_q <= flag_d;
    end
  end

  // Tape motion
  logic on;
  logic powered;
  logic on_next;
  logic fwd;
  logic rev;
  logic [POS_W-1:0] pos_q;
  logic at_start;
  logic at_mid;
  logic at_end;
  logic moving;
  logic [2:0] mark_now;
  logic [2:0] mark_q;
  logic [1:0] dir_q;
  logic restart;
  logic [31:0] spd_q;
  logic [31:0] spd_d;
  logic [31:0] step_q;
  logic step_evt;
  logic fwd_ok_q;
  logic rev_ok_q;

  assign on = (st_q == ST_ON);
  assign powered = (st_q != ST_OFF);
  // Speed status drops together with leaving on, not a cycle later
  assign on_next = (st_d == ST_ON);
  assign fwd = on && cmd.advance_cmd && !cmd.rewind_cmd;
  assign rev = on && cmd.rewind_cmd && !cmd.advance_cmd;
  assign at_start = (pos_q == '0);
  assign at_mid = (pos_q == POS_W'(TAPE_WORDS / 2));
  assign at_end = (pos_q == POS_W'(TAPE_WORDS - 1));
  // Tape stops against its physical ends
  assign moving = (fwd && !at_end) || (rev && !at_start);
  assign mark_now = powered ? {at_start, at_mid, at_end} : 3'h0;
  assign restart = ({fwd, rev} != dir_q) || ((mark_q & ~mark_now) != 3'h0);
  assign spd_d = (!(fwd || rev) || restart) ? 32'h0 :
                 (spd_q == 32'(SPEED_CYC)) ? spd_q : spd_q + 32'h1;
  assign step_evt = moving && (step_q == 32'(STEP_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q <= '0;
      mark_q <= 3'h0;
      dir_q <= 2'h0;
      spd_q <= 32'h0;
      step_q <= 32'h0;
      fwd_ok_q <= 1'b0;
      rev_ok_q <= 1'b0;
    end
    else
    begin
      mark_q <= mark_now;
      dir_q <= {fwd, rev};
      spd_q <= spd_d;
      fwd_ok_q <= fwd && on_next && (spd_d == 32'(SPEED_CYC));
      rev_ok_q <= rev && on_next && (spd_d == 32'(SPEED_CYC));
      step_q <= step_evt || !moving ? 32'h0 : step_q + 32'h1;
      if (step_evt)
        pos_q <= fwd ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
    end
  end

  // Tape store: one word per track group per position
  logic [TRACKS-1:0] mem_q [TAPE_WORDS];
  logic rec_we;
  logic erase_we;
  logic mem_we;
  logic [TRACKS-1:0] mem_wd;

  assign rec_we = on && cmd.write_enable_level && cmd.write_lockout_n && strobe_rise;
  assign erase_we = powered && cmd.erase_override && cmd.write_lockout_n;
  assign mem_we = rec_we || erase_we;
  assign mem_wd = erase_we ? '0 : wr_data;

  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_q[pos_q] <= mem_wd;
  end

  // Replay: one pulse per position passed while reading
  logic rd_go;
  logic [TRACKS-1:0] rd_q;
  logic [31:0] rdc_q;

  assign rd_go = on && cmd.read_cmd && step_evt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= '0;
      rdc_q <= 32'h0;
    end
    else if (rd_go)
    begin
      rd_q <= mem_q[pos_q];
      rdc_q <= 32'(READ_CYC);
    end
    else if (rdc_q == 32'h1 || !powered)
    begin
      rd_q <= '0;
      rdc_q <= 32'h0;
    end
    else if (rdc_q != 32'h0)
      rdc_q <= rdc_q - 32'h1;
  end

  // Bus slave: one wait cycle, then the answer
  always_comb
  begin
    status_w = 32'h0;
    status_w[STAT_STATE_LSB +: 3] = st_q;
    status_w[STAT_FLAG_BIT] = flag_q;
    status_w[STAT_NRDY_BIT] = nrdy_q;
    status_w[STAT_FWD_BIT] = fwd_ok_q;
    status_w[STAT_REV_BIT] = rev_ok_q;
    status_w[STAT_MARK_LSB +: 3] = mark_q;
  end

  assign rdata_w = (avs_address == REG_CTRL) ? {31'h0, fault_q} :
                   (avs_address == REG_STATUS) ? status_w :
                   (avs_address == REG_POS) ? 32'(pos_q) : 32'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      fault_q <= CTRL_FAULT_RST;
    end
    else
    begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q)
        rdata_q <= avs_read ? rdata_w : 32'h0;
      if (bus_done && avs_write && avs_address == REG_CTRL && avs_byteenable[0])
        fault_q <= avs_writedata[CTRL_FAULT_BIT];
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign read_track = rd_q;
  assign tape_start_mark = mark_q[2];
  assign tape_middle_mark = mark_q[1];
  assign tape_end_mark = mark_q[0];
  assign speed_ok_forward = fwd_ok_q;
  assign speed_ok_reverse = rev_ok_q;
  assign not_ready_n = nrdy_q;
  assign supply_fail_flag = flag_q;

  // Checks; a helper counts cycles spent in the current state
  logic [31:0] age_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      age_q <= 32'h0;
    else
      age_q <= (st_d != st_q) ? 32'h0 : age_q + 32'h1;
  end

  sequence s_to_standby;
    st_q == ST_STANDBY ##1 nrdy_q && !flag_q;
  endsequence

  property p_lockout;
    !cmd.write_lockout_n |-> !mem_we;
  endproperty
  a_lockout: assert property (p_lockout) else $error("write while locked out");

  property p_one_word;
    rec_we |=> !rec_we;
  endproperty
  a_one_word: assert property (p_one_word) else $error("strobe wrote twice");

  property p_wr_level;
    rec_we |-> $past(cmd_pins.write_enable_level, 2) && $past(cmd_pins.write_lockout_n, 2);
  endproperty
  a_wr_level: assert property (p_wr_level) else $error("record without enable");

  property p_ignore;
    !on |-> !rec_we && !step_evt && !fwd_ok_q && !rev_ok_q;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command acted on while not on");

  property p_offline;
    (on && !op_en && !power_bad) |=> s_to_standby;
  endproperty
  a_offline: assert property (p_offline) else $error("enable removal mishandled");

  property p_flag_norm;
    (st_q inside {ST_STANDBY, ST_WARMUP, ST_ON, ST_FAIL_WAIT}) |-> !supply_fail_flag;
  endproperty
  a_flag_norm: assert property (p_flag_norm) else $error("flag high in normal state");

  property p_off_flag;
    st_q == ST_OFF |-> supply_fail_flag && not_ready_n && read_track == '0;
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("off state outputs wrong");

  property p_fail_delay;
    (st_q == ST_FAIL_WAIT && st_d == ST_FAIL_HOLD) |-> age_q == 32'(FAIL_CYC - 1);
  endproperty
  a_fail_delay: assert property (p_fail_delay) else $error("flag raised too soon");

  property p_lead;
    (st_q == ST_FAIL_HOLD && st_d == ST_OFF) |-> supply_fail_flag && age_q == 32'(LEAD_CYC - 1);
  endproperty
  a_lead: assert property (p_lead) else $error("outputs blanked before lead time");

  property p_ready;
    $fell(not_ready_n) |-> $past(st_q) == ST_WARMUP && $past(age_q) < 32'(READY_MAX_CYC);
  endproperty
  a_ready: assert property (p_ready) else $error("ready late or from wrong state");

  property p_speed;
    $rose(speed_ok_forward) || $rose(speed_ok_reverse) |-> spd_q == 32'(SPEED_CYC);
  endproperty
  a_speed: assert property (p_speed) else $error("speed ok at wrong time");

  property p_standby;
    (st_q == ST_POWERUP && st_d == ST_STANDBY) |=> !supply_fail_flag ##1 st_q != ST_OFF;
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");

endmodule : tape_unit_ctrl

`default_nettype wire

/* rtl/tape_unit_pkg.sv */
// Constants and types shared by the tape unit control interface
package tape_unit_pkg;

  localparam int CLK_MHZ = 125;
  localparam int TRACKS = 18;

  // Times in their own units
  localparam int STANDBY_MS = 100;
  localparam int READY_MAX_MS = 500;
  localparam int READY_MS = 100;
  localparam int OFFLINE_MAX_US = 50;
  localparam int FAIL_MIN_US = 300;
  localparam int LEAD_MIN_US = 10;
  localparam int SPEED_MS = 1000;
  localparam int SPEED_TOL_PCT = 10;
  localparam int READ_PULSE_US = 38;
  localparam int SYNC_LOSS_US = 80;
  localparam int STEP_US = 400;

  // Derived cycle counts
  localparam int STANDBY_CYC_D = STANDBY_MS * 1000 * CLK_MHZ;
  localparam int READY_CYC_D = READY_MS * 1000 * CLK_MHZ;
  localparam int READY_MAX_CYC_D = READY_MAX_MS * 1000 * CLK_MHZ;
  localparam int OFFLINE_MAX_CYC = OFFLINE_MAX_US * CLK_MHZ;
  localparam int FAIL_CYC_D = FAIL_MIN_US * CLK_MHZ;
  localparam int LEAD_CYC = LEAD_MIN_US * CLK_MHZ;
  localparam int SPEED_CYC_D = SPEED_MS * 1000 * CLK_MHZ;
  localparam int READ_CYC_D = READ_PULSE_US * CLK_MHZ;
  localparam int SYNC_LOSS_CYC_D = SYNC_LOSS_US * CLK_MHZ;
  localparam int STEP_CYC_D = STEP_US * CLK_MHZ;

  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_POS = 4'h8;
  localparam int CTRL_FAULT_BIT = 0;
  localparam logic CTRL_FAULT_RST = 1'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FLAG_BIT = 4;
  localparam int STAT_NRDY_BIT = 5;
  localparam int STAT_FWD_BIT = 6;
  localparam int STAT_REV_BIT = 7;
  localparam int STAT_MARK_LSB = 8;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_POWERUP,
    ST_STANDBY,
    ST_WARMUP,
    ST_ON,
    ST_FAIL_WAIT,
    ST_FAIL_HOLD
  } pwr_state_t;

  typedef struct packed {
    logic rewind_cmd;
    logic advance_cmd;
    logic read_cmd;
    logic word_write_strobe;
    logic write_enable_level;
    logic write_lockout_n;
    logic erase_override;
  } tape_cmd_t;

endpackage : tape_unit_pkg
